// ### rtl/rwc_pkg.sv
package rwc_pkg;

    // Timing, one oscillator period per core_clk cycle
    localparam int CLK_HZ           = 50_000_000;
    localparam int POWERUP_TIMER_TIME_US     = 72_000;
    localparam int POWERUP_TIMER_CYCLES      = POWERUP_TIMER_TIME_US * (CLK_HZ / 1_000_000);
    localparam int OST_TOSC         = 1024;
    localparam int OST_CYCLES       = OST_TOSC;
    localparam int POR_DELAY_CYCLES = 16;
    localparam int CNT_W            = 22;
    localparam int PC_W             = 13;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CORE_IRQ_CTRL     = 8'h0B;
    localparam logic [7:0] IDX_CORE_IRQ_CTRL_ALT = 8'h8B;
    localparam logic [7:0] IDX_PERIPH_FLAGS      = 8'h0C;
    localparam logic [7:0] IDX_PERIPH_ENABLES    = 8'h8C;
    localparam logic [7:0] IDX_POWER_CTRL        = 8'h8E;
    localparam logic [7:0] IDX_RESET_STATUS      = 8'h90;

    // core_interrupt_control fields
    localparam int GIE_BIT  = 7;
    localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
    localparam int T0IE_BIT = 5;
    localparam int PORT_CHANGE_ENABLE_BIT = 3;
    localparam int T0IF_BIT = 2;
    localparam int EXT_PIN_IRQ_FLAG_BIT = 1;
    localparam int PORT_CHANGE_FLAG_BIT = 0;

    // peripheral_interrupt_flags / enables fields
    localparam int ADC_BIT  = 6;
    localparam int CCP_BIT  = 2;
    localparam int TMR2_BIT = 1;
    localparam int TMR1_BIT = 0;
    localparam logic [7:0] PERIPH_MASK = 8'h47;

    // power_control_status and reset status fields
    localparam int BOR_BIT   = 0;
    localparam int POR_BIT   = 1;
    localparam logic [7:0] POWER_CONTROL_STATUS_MASK = 8'h03;
    localparam int PD_BIT    = 0;
    localparam int TO_BIT    = 1;
    localparam int SLEEP_BIT = 2;

    // Reset values
    localparam logic [7:0] CORE_IRQ_RESET  = 8'h00;
    localparam logic [7:0] PERIPH_RESET    = 8'h00;
    localparam logic [7:0] OPTION_RESET    = 8'hFF;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] TIMER2_RESET    = 8'h00;
    localparam logic [7:0] PERIOD2_RESET   = 8'hFF;
    localparam logic [PC_W-1:0] VEC_RESET  = 13'h0000;
    localparam logic [PC_W-1:0] VEC_IRQ    = 13'h0004;

    typedef enum logic [2:0] {
        ST_POR   = 3'b000,
        ST_POWERUP_TIMER  = 3'b001,
        ST_OST   = 3'b010,
        ST_HOLD  = 3'b011,
        ST_RUN   = 3'b100,
        ST_SLEEP = 3'b101,
        ST_WAKE  = 3'b110,
        ST_BROWN = 3'b111
    } rwc_state_e_t;

    typedef struct packed {
        rwc_state_e_t    state;
        logic [CNT_W-1:0] cnt;
        logic [2:0]      pin_s1;
        logic [2:0]      pin_s2;
        logic            ext_s3;
        logic [2:0]      fuse_s1;
        logic [2:0]      fuse_s2;
        logic [7:0]      core_interrupt_control;
        logic [7:0]      pir;
        logic [7:0]      pie;
        logic            por_n;
        logic            bor_n;
        logic            to_n;
        logic            pd_n;
        logic            pend;
        logic            waitreq;
        logic [31:0]     rdata;
        logic            core_reset;
        logic            sleeping;
        logic            pc_load;
        logic [PC_W-1:0] pc_value;
        logic            irq_vector;
        logic            resume;
        logic            wdt_clear;
        logic            sfr_init;
    } rwc_regs_t;

endpackage

// ### rtl/rwc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Power-up runs reset delay, then power-up timer, then oscillator start-up.
// - Crystal: 72 ms plus 1024 periods, or 1024 only; RC: 72 ms or none.
// - Time-outs run under master clear; release afterwards starts at once.
// - Brown-out status reads one after power-on; brown-out reset clears it.
// - Power-on status cleared only by power-on; software sets it afterwards.
// - Time-out and power-down flags follow the kind of reset or wake.
// - Resets load program counter 000h; wake-ups continue at PC + 1.
// - Special registers take reset values; wake-ups touch only interrupt flags.
// - Seven sources; flags set regardless of any enable.
// - Global enable with flag and enable vectors at once; clear blocks all.
// - Every reset clears the global interrupt enable.
// - Return-from-interrupt sets the global enable again.
// - Accepting clears global enable, pushes return address, loads 0004h.
// - Core register: enables bits 7 to 3, flags bits 2 to 0.
// - Peripheral flags and enables apart, gated by one group enable.
// - External event to vector takes three or four instruction cycles.
// - Sleep prefetches next instruction; enabled source wakes, global ignored.
// - Wake with global clear continues; set runs next instruction, then 0004h.
// - Enabled flag already set makes sleep a no-operation.
// - Interrupt during sleep: sleep completes, device wakes immediately.
// - Peripheral flags set by hardware, cleared by software or by any reset.
module rwc_top
    import rwc_pkg::*;
#(
    parameter int POR_CYCLES  = POR_DELAY_CYCLES,
    parameter int POWERUP_TIMER_CNT    = POWERUP_TIMER_CYCLES,
    parameter int OST_CNT     = OST_CYCLES
)(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic [9:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic             master_clear_n,
    input  wire logic             brownout_detect,
    input  wire logic             ext_irq_pin,
    input  wire logic             brownout_detect_fuse,
    input  wire logic             powerup_timer_fuse_n,
    input  wire logic             osc_mode_rc,
    input  wire logic             watchdog_timeout,
    input  wire logic             instr_cycle_tick,
    input  wire logic             sleep_instr,
    input  wire logic             return_from_irq_instr,
    input  wire logic             watchdog_clear_instr,
    input  wire logic             timer0_overflow_event,
    input  wire logic             port_change_event,
    input  wire logic             timer1_overflow_event,
    input  wire logic             timer2_match_event,
    input  wire logic             capture_compare_event,
    input  wire logic             conversion_done_event,
    output logic                  core_reset,
    output logic                  sleeping,
    output logic                  pc_load,
    output logic [PC_W-1:0]       pc_value,
    output logic                  irq_vector,
    output logic                  resume,
    output logic                  watchdog_clear,
    output logic                  sfr_init
);

    localparam logic [CNT_W-1:0] POR_LAST  = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0] POWERUP_TIMER_LAST = CNT_W'(POWERUP_TIMER_CNT - 1);
    localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_CNT - 1);

    function automatic logic irq_combine(
        input logic [7:0] ic,
        input logic [7:0] pf,
        input logic [7:0] pe,
        input logic       gate
    );
        logic core_any;
        logic peri_any;
        core_any = |(ic[T0IE_BIT:PORT_CHANGE_ENABLE_BIT] & ic[T0IF_BIT:PORT_CHANGE_FLAG_BIT]);
        peri_any = ic[PERIPHERAL_GROUP_ENABLE_BIT] & (|(pf & pe & PERIPH_MASK));
        return gate & (core_any | peri_any);
    endfunction

    function automatic logic idx_hit(
        input logic [9:0] addr,
        input logic [7:0] idx
    );
        return addr[9:2] == idx;
    endfunction

    rwc_regs_t q;
    rwc_regs_t d;

    logic       irq_now;
    logic       wake_now;
    logic       master_clear_n_s;
    logic       bo_s;
    logic       ext_rise;
    logic       crystal;
    logic       rst_evt;
    logic       wr_en;
    logic [2:0] core_set;
    logic [7:0] peri_set;
    logic [7:0] rd_mux;
    logic [7:0] wdata;

    always_comb
    begin
        d            = q;
        d.pc_load    = 1'b0;
        d.irq_vector = 1'b0;
        d.resume     = 1'b0;
        d.wdt_clear  = 1'b0;
        d.sfr_init   = 1'b0;
        rst_evt      = 1'b0;
        wdata        = avs_writedata[7:0];

        d.pin_s1  = {brownout_detect, ext_irq_pin, master_clear_n};
        d.pin_s2  = q.pin_s1;
        d.ext_s3  = q.pin_s2[1];
        d.fuse_s1 = {osc_mode_rc, powerup_timer_fuse_n, brownout_detect_fuse};
        d.fuse_s2 = q.fuse_s1;
        master_clear_n_s    = q.pin_s2[0];
        bo_s      = q.pin_s2[2] & q.fuse_s2[0];
        ext_rise  = q.pin_s2[1] & ~q.ext_s3;
        crystal   = ~q.fuse_s2[2];

        irq_now  = irq_combine(q.core_interrupt_control, q.pir, q.pie,
                               q.core_interrupt_control[GIE_BIT]);
        wake_now = irq_combine(q.core_interrupt_control, q.pir, q.pie, 1'b1);

        // Bus slave: one wait cycle, then answer
        wr_en = avs_write & ~q.waitreq & avs_byteenable[0];
        case (avs_address[9:2])
            IDX_CORE_IRQ_CTRL:     rd_mux = q.core_interrupt_control;
            IDX_CORE_IRQ_CTRL_ALT: rd_mux = q.core_interrupt_control;
            IDX_PERIPH_FLAGS:      rd_mux = q.pir & PERIPH_MASK;
            IDX_PERIPH_ENABLES:    rd_mux = q.pie & PERIPH_MASK;
            IDX_POWER_CTRL:        rd_mux = {6'h00, q.por_n, q.bor_n};
            IDX_RESET_STATUS:      rd_mux = {5'h00, q.sleeping, q.to_n, q.pd_n};
            default:               rd_mux = 8'h00;
        endcase
        if ((avs_read | avs_write) & q.waitreq)
        begin
            d.waitreq = 1'b0;
            d.rdata   = {24'h0000_00, rd_mux};
        end
        else
        begin
            d.waitreq = 1'b1;
        end

        if (wr_en && (idx_hit(avs_address, IDX_CORE_IRQ_CTRL) ||
                      idx_hit(avs_address, IDX_CORE_IRQ_CTRL_ALT)))
            d.core_interrupt_control = wdata;
        if (wr_en && idx_hit(avs_address, IDX_PERIPH_FLAGS))
            d.pir = wdata & PERIPH_MASK;
        if (wr_en && idx_hit(avs_address, IDX_PERIPH_ENABLES))
            d.pie = wdata & PERIPH_MASK;
        if (wr_en && idx_hit(avs_address, IDX_POWER_CTRL))
        begin
            d.por_n = wdata[POR_BIT];
            d.bor_n = wdata[BOR_BIT];
        end

        // Hardware set applied after the write so a same-cycle clear loses
        core_set = {timer0_overflow_event, ext_rise, port_change_event};
        d.core_interrupt_control[T0IF_BIT:PORT_CHANGE_FLAG_BIT] = d.core_interrupt_control[T0IF_BIT:PORT_CHANGE_FLAG_BIT]
                                      | core_set;
        peri_set           = 8'h00;
        peri_set[ADC_BIT]  = conversion_done_event;
        peri_set[CCP_BIT]  = capture_compare_event;
        peri_set[TMR2_BIT] = timer2_match_event;
        peri_set[TMR1_BIT] = timer1_overflow_event;
        d.pir = d.pir | peri_set;

        case (q.state)
            ST_POR:
            begin
                // Master clear does not stop the time-outs
                if (q.cnt >= POR_LAST)
                begin
                    d.cnt   = '0;
                    d.bor_n = 1'b1;
                    if (!q.fuse_s2[1])
                        d.state = ST_POWERUP_TIMER;
                    else if (crystal)
                        d.state = ST_OST;
                    else
                        d.state = ST_HOLD;
                end
                else
                    d.cnt = q.cnt + 1'b1;
            end
            ST_POWERUP_TIMER:
            begin
                if (q.cnt >= POWERUP_TIMER_LAST)
                begin
                    d.cnt   = '0;
                    d.state = crystal ? ST_OST : ST_HOLD;
                end
                else
                    d.cnt = q.cnt + 1'b1;
            end
            ST_OST:
            begin
                if (q.cnt >= OST_LAST)
                begin
                    d.cnt   = '0;
                    d.state = ST_HOLD;
                end
                else
                    d.cnt = q.cnt + 1'b1;
            end
            ST_HOLD:
            begin
                // Time-outs already spent, so release starts at once
                if (master_clear_n_s)
                begin
                    d.state    = ST_RUN;
                    d.pc_load  = 1'b1;
                    d.pc_value = VEC_RESET;
                end
            end
            ST_BROWN:
            begin
                // Brown-out always takes the power-up timer
                if (!bo_s)
                begin
                    d.cnt   = '0;
                    d.state = ST_POWERUP_TIMER;
                end
            end
            ST_RUN:
            begin
                if (return_from_irq_instr)
                    d.core_interrupt_control[GIE_BIT] = 1'b1;
                if (watchdog_clear_instr)
                begin
                    d.wdt_clear = 1'b1;
                    d.to_n      = 1'b1;
                    d.pd_n      = 1'b1;
                end
                if (instr_cycle_tick)
                begin
                    // Pending stage gives the 3-4 cycle latency
                    if (q.pend && irq_now)
                    begin
                        d.core_interrupt_control[GIE_BIT] = 1'b0;
                        d.irq_vector      = 1'b1;
                        d.pc_load         = 1'b1;
                        d.pc_value        = VEC_IRQ;
                        d.pend            = 1'b0;
                    end
                    else
                        d.pend = irq_now;
                end
                if (watchdog_timeout)
                begin
                    d.to_n  = 1'b0;
                    d.pd_n  = 1'b1;
                    d.state = ST_HOLD;
                    rst_evt = 1'b1;
                end
                else if (sleep_instr && !wake_now)
                begin
                    // No enabled flag pending: sleep clears the watchdog and enters ST_SLEEP
                    d.wdt_clear = 1'b1;
                    d.to_n      = 1'b1;
                    d.pd_n      = 1'b0;
                    d.state     = ST_SLEEP;
                    d.pend      = 1'b0;
                end
            end
            ST_SLEEP:
            begin
                if (watchdog_timeout || wake_now)
                begin
                    if (watchdog_timeout)
                        d.to_n = 1'b0;
                    d.cnt = '0;
                    if (crystal)
                        d.state = ST_WAKE;
                    else
                    begin
                        d.state  = ST_RUN;
                        d.resume = 1'b1;
                        d.pend   = q.core_interrupt_control[GIE_BIT];
                    end
                end
            end
            ST_WAKE:
            begin
                if (q.cnt >= OST_LAST)
                begin
                    d.cnt    = '0;
                    d.state  = ST_RUN;
                    d.resume = 1'b1;
                    d.pend   = q.core_interrupt_control[GIE_BIT];
                end
                else
                    d.cnt = q.cnt + 1'b1;
            end
            default:
                d.state = ST_HOLD;
        endcase

        // Brown-out wins over master clear; both outrank the above
        if (bo_s && q.state != ST_POR)
        begin
            d.state = ST_BROWN;
            d.bor_n = 1'b0;
            d.to_n  = 1'b1;
            d.pd_n  = 1'b1;
            d.cnt   = '0;
            rst_evt = 1'b1;
        end
        else if (!master_clear_n_s && (q.state == ST_RUN || q.state == ST_SLEEP ||
                             q.state == ST_WAKE))
        begin
            if (q.state != ST_RUN)
            begin
                d.to_n = 1'b1;
                d.pd_n = 1'b0;
            end
            d.state = ST_HOLD;
            rst_evt = 1'b1;
        end

        if (rst_evt)
        begin
            // Flag of port change survives non power-on resets
            d.core_interrupt_control = {CORE_IRQ_RESET[7:1], d.core_interrupt_control[PORT_CHANGE_FLAG_BIT]};
            d.pir        = PERIPH_RESET;
            d.pie        = PERIPH_RESET;
            d.pend       = 1'b0;
            d.irq_vector = 1'b0;
            d.resume     = 1'b0;
            d.pc_load    = 1'b0;
            d.sfr_init   = 1'b1;
        end

        d.core_reset = !(d.state == ST_RUN || d.state == ST_SLEEP ||
                         d.state == ST_WAKE);
        d.sleeping   = (d.state == ST_SLEEP || d.state == ST_WAKE);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            // Power-on: flags per power-on, waitreq, core_reset and sfr_init set, everything else cleared
            q            <= '0;
            q.state      <= ST_POR;
            q.core_interrupt_control     <= CORE_IRQ_RESET;
            q.pir        <= PERIPH_RESET;
            q.pie        <= PERIPH_RESET;
            q.por_n      <= 1'b0;
            q.bor_n      <= 1'b1;
            q.to_n       <= 1'b1;
            q.pd_n       <= 1'b1;
            q.waitreq    <= 1'b1;
            q.core_reset <= 1'b1;
            q.sfr_init   <= 1'b1;
        end
        else if (clk_en)
            q <= d;
    end

    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign core_reset      = q.core_reset;
    assign sleeping        = q.sleeping;
    assign pc_load         = q.pc_load;
    assign pc_value        = q.pc_value;
    assign irq_vector      = q.irq_vector;
    assign resume          = q.resume;
    assign watchdog_clear  = q.wdt_clear;
    assign sfr_init        = q.sfr_init;

endmodule

// ### tb/rwc_core_model.sv
`timescale 1ns/1ps
module rwc_core_model
    import rwc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic core_reset,
    input  wire logic sleeping,
    input  wire logic irq_vector,
    input  wire logic resume,
    input  wire logic watchdog_clear,
    output logic      instr_cycle_tick,
    output int        vec_cnt,
    output int        res_cnt,
    output int        wdc_cnt
);
    logic [1:0] ph = 2'h0;
    // Four clocks per instruction cycle; a halted core issues no ticks
    assign instr_cycle_tick = (ph == 2'h3);
    initial
    begin
        vec_cnt = 0;
        res_cnt = 0;
        wdc_cnt = 0;
    end
    always @(posedge core_clk)
    begin
        ph <= (core_reset || sleeping) ? 2'h0 : ph + 2'h1;
        vec_cnt <= vec_cnt + int'(irq_vector);
        res_cnt <= res_cnt + int'(resume);
        wdc_cnt <= wdc_cnt + int'(watchdog_clear);
    end
endmodule

// ### tb/rwc_top_sva.sv
`timescale 1ns/1ps
module rwc_top_sva
    import rwc_pkg::*;
(
    input wire logic            core_clk,
    input wire logic            rst_n,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic            avs_waitrequest,
    input wire logic            core_reset,
    input wire logic            sleeping,
    input wire logic            pc_load,
    input wire logic [PC_W-1:0] pc_value,
    input wire logic            irq_vector,
    input wire logic            resume,
    input wire logic            sfr_init
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence req_taken_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answer_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property (req_taken_s |=> answer_s)
        else $error("bus answer not one cycle");
    reset_out_a: assert property (disable iff (1'b0)
        !rst_n |=> core_reset && sfr_init && avs_waitrequest)
        else $error("reset outputs wrong");
    boot_vec_a: assert property ($fell(core_reset)
        |-> ##[0:1] (pc_load && pc_value == VEC_RESET))
        else $error("no reset vector load");
    irq_target_a: assert property (irq_vector
        |-> pc_load && pc_value == VEC_IRQ)
        else $error("vector address wrong");
    vec_once_a: assert property (irq_vector |=> !irq_vector [*4])
        else $error("vector repeated");
    halt_quiet_a: assert property (core_reset
        |-> !irq_vector && !resume)
        else $error("activity in reset");
    sleep_novec_a: assert property (sleeping |-> !irq_vector)
        else $error("vector while asleep");
    wake_from_a: assert property (resume |-> $past(sleeping))
        else $error("resume without sleep");
endmodule
bind rwc_top rwc_top_sva i_rwc_top_sva (.core_clk(core_clk), .rst_n(rst_n),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .core_reset(core_reset),
    .sleeping(sleeping), .pc_load(pc_load), .pc_value(pc_value),
    .irq_vector(irq_vector), .resume(resume), .sfr_init(sfr_init));

// ### tb/rwc_top_tb.sv
`timescale 1ns/1ps
module rwc_top_tb
    import rwc_pkg::*;
;
    localparam int TN = 4 + 20 + 8;
    logic            core_clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            master_clear_n = 1'b1;
    logic            brownout_detect = 1'b0;
    logic            ext_irq_pin = 1'b0;
    logic [9:0]      pls = 10'h000;
    logic [9:0]      avs_address = 10'h000;
    logic            avs_read = 1'b0;
    logic            avs_write = 1'b0;
    logic [31:0]     avs_writedata = 32'h0000_0000;
    logic            clk_en = 1'b1;
    logic [3:0]      avs_byteenable = 4'hF;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest, core_reset, sleeping, pc_load;
    logic            irq_vector, resume, watchdog_clear, sfr_init, tick;
    logic [PC_W-1:0] pc_value;
    logic [7:0]      rd;
    int              vec_cnt, res_cnt, wdc_cnt, n;
    int              err_total = 0;
    int              tests_run = 0;

    rwc_top #(.POR_CYCLES(4), .POWERUP_TIMER_CNT(20), .OST_CNT(8)) i_rwc_top (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .master_clear_n(master_clear_n),
        .brownout_detect(brownout_detect), .ext_irq_pin(ext_irq_pin),
        .brownout_detect_fuse(1'b1), .powerup_timer_fuse_n(1'b0),
        .osc_mode_rc(1'b0), .watchdog_timeout(pls[9]),
        .instr_cycle_tick(tick), .sleep_instr(pls[6]),
        .return_from_irq_instr(pls[7]), .watchdog_clear_instr(pls[8]),
        .timer0_overflow_event(pls[0]), .port_change_event(pls[1]),
        .timer1_overflow_event(pls[2]), .timer2_match_event(pls[3]),
        .capture_compare_event(pls[4]), .conversion_done_event(pls[5]),
        .core_reset(core_reset), .sleeping(sleeping), .pc_load(pc_load),
        .pc_value(pc_value), .irq_vector(irq_vector), .resume(resume),
        .watchdog_clear(watchdog_clear), .sfr_init(sfr_init));

    rwc_core_model i_rwc_core_model (
        .core_clk(core_clk), .core_reset(core_reset), .sleeping(sleeping),
        .irq_vector(irq_vector), .resume(resume),
        .watchdog_clear(watchdog_clear), .instr_cycle_tick(tick),
        .vec_cnt(vec_cnt), .res_cnt(res_cnt), .wdc_cnt(wdc_cnt));

    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic stop_test();
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic hang();
        err_total++;
        $display("mismatch at %0t: wait ran out", $time);
        stop_test();
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Idle edge first so a strobe is never lowered and raised at one step
    task automatic bus(input logic wr_en, input logic [7:0] idx,
                       input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge core_clk);
        avs_address <= {idx, 2'h0};
        avs_writedata <= {24'h00_0000, wd};
        avs_write <= wr_en;
        avs_read <= !wr_en;
        // Look mid-cycle, act on the following rising edge
        do
        begin
            @(negedge core_clk);
            k++;
            if (k > 50)
                hang();
        end
        while (avs_waitrequest !== 1'b0);
        @(posedge core_clk);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp,
                       input logic [7:0] mask);
        bus(1'b0, idx, 8'h00);
        chk8(rd & mask, exp);
    endtask

    task automatic pulse(input logic [9:0] m);
        @(posedge core_clk);
        pls <= m;
        @(posedge core_clk);
        pls <= 10'h000;
    endtask

    // sel 0: core out of reset, 1: resume count, 2: vector count
    task automatic wait_until(input int sel, input int tgt, input int lim);
        n = 0;
        while (!(sel == 0 ? core_reset === 1'b0 :
                 sel == 1 ? res_cnt >= tgt : vec_cnt >= tgt))
        begin
            @(posedge core_clk);
            n++;
            if (n > lim)
                hang();
        end
    endtask

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_until(0, 0, 200);
        chk8(8'(n >= TN && n <= TN + 12), 8'h01);
        rdc(8'h0B, 8'h00, 8'hFE);
        rdc(8'h0C, 8'h00, 8'hFF);
        rdc(8'h8C, 8'h00, 8'hFF);
        rdc(8'h8E, 8'h01, 8'h03);
        rdc(8'h90, 8'h03, 8'h07);
        rdc(8'h40, 8'h00, 8'hFF);
        avs_byteenable <= 4'h0;
        wr(8'h8E, 8'h02);
        avs_byteenable <= 4'hF;
        rdc(8'h8E, 8'h01, 8'h03);
        wr(8'h8E, 8'h03);
        rdc(8'h8E, 8'h03, 8'h03);
        ext_irq_pin <= 1'b1;
        pulse(10'h03F);
        rdc(8'h0B, 8'h07, 8'hFF);
        rdc(8'h0C, 8'h47, 8'hFF);
        wr(8'h0C, 8'h00);
        wr(8'h0B, 8'h00);
        ext_irq_pin <= 1'b0;
        rdc(8'h0C, 8'h00, 8'hFF);
        wr(8'h0B, 8'h10);
        ext_irq_pin <= 1'b1;
        repeat (40) @(posedge core_clk);
        chk8(8'(vec_cnt), 8'h00);
        wr(8'h0B, 8'h10);
        ext_irq_pin <= 1'b0;
        wr(8'h8B, 8'h90);
        repeat (4) @(posedge core_clk);
        ext_irq_pin <= 1'b1;
        wait_until(2, 1, 40);
        chk8(8'(n <= 16), 8'h01);
        rdc(8'h0B, 8'h12, 8'hFF);
        wr(8'h0B, 8'h10);
        pulse(10'h080);
        rdc(8'h0B, 8'h90, 8'hFF);
        wr(8'h0B, 8'h00);
        ext_irq_pin <= 1'b0;
        wr(8'h8C, 8'h02);
        pulse(10'h008);
        wr(8'h0B, 8'h80);
        repeat (20) @(posedge core_clk);
        chk8(8'(vec_cnt), 8'h01);
        wr(8'h0B, 8'hC0);
        wait_until(2, 2, 40);
        wr(8'h0C, 8'h00);
        wr(8'h0B, 8'h20);
        pulse(10'h100);
        pulse(10'h040);
        rdc(8'h90, 8'h06, 8'h07);
        chk8(8'(wdc_cnt), 8'h02);
        pulse(10'h001);
        wait_until(1, 1, 40);
        repeat (12) @(posedge core_clk);
        chk8(8'(vec_cnt), 8'h02);
        rdc(8'h90, 8'h02, 8'h07);
        pulse(10'h040);
        rdc(8'h90, 8'h02, 8'h07);
        chk8(8'(wdc_cnt), 8'h02);
        wr(8'h0B, 8'hA0);
        pulse(10'h040);
        pulse(10'h001);
        wait_until(2, 3, 60);
        chk8(8'(res_cnt), 8'h02);
        wr(8'h0B, 8'h80);
        pulse(10'h200);
        wait_until(0, 0, 200);
        rdc(8'h90, 8'h01, 8'h07);
        rdc(8'h0B, 8'h00, 8'hFE);
        rdc(8'h8C, 8'h00, 8'hFF);
        rdc(8'h8E, 8'h03, 8'h03);
        master_clear_n <= 1'b0;
        brownout_detect <= 1'b1;
        repeat (4) @(posedge core_clk);
        brownout_detect <= 1'b0;
        repeat (TN + 12) @(posedge core_clk);
        chk8(8'(core_reset), 8'h01);
        master_clear_n <= 1'b1;
        wait_until(0, 0, 8);
        rdc(8'h8E, 8'h02, 8'h03);
        stop_test();
    end
endmodule
